// ==== eprom_lock_protection.sv ====
// Lock bits, encryption array and signature for the program EPROM
// Contract
// R1 - Sixty-four byte encryption array, every byte erased to all ones.
// R2 - Six low code address bits select the encryption byte on verify.
// R3 - Verify output is code byte XNOR selected encryption byte.
// R4 - Programmer should fill unused code with random bytes.
// R5 - Three independently programmable lock bits choose four levels.
// R6 - Level 1: no locks; verify still encrypted; table reads plain.
// R7 - Level 2: block external table reads, latch pin, stop programming.
// R8 - Level 3: level 2 plus verify disabled.
// R9 - Level 4: level 3 plus external execution disabled.
// R10 - Programmer should lock levels 2 and 3 only after verifying.
// R11 - Four fixed signature bytes readable, never alterable.
// R12 - Several programmed lock bits give the highest level indicated.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module eprom_lock_protection #(
  parameter logic [31:0] SIGNATURE = 32'h5A5A_A5A5 // Arbitrary value
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic VFY_REQ_I,
  input wire logic [15:0] VFY_ADDR_I,
  input wire logic [7:0] VFY_CODE_I,
  output logic VFY_VALID_O,
  output logic VFY_DENY_O,
  output logic [7:0] VFY_DATA_O,
  input wire logic TBL_RD_REQ_I,
  input wire logic TBL_RD_EXT_I,
  input wire logic [7:0] TBL_RD_CODE_I,
  output logic TBL_RD_VALID_O,
  output logic TBL_RD_DENY_O,
  output logic [7:0] TBL_RD_DATA_O,
  input wire logic EXTERNAL_ACCESS_SELECT_I,
  output logic EXTERNAL_ACCESS_SELECT_O,
  output logic EXT_EXEC_ALLOW_O,
  output logic CODE_PROG_ALLOW_O,
  output logic [1:0] PROT_LEVEL_O
);

  // Bus slave state
  logic aw_hold, next_aw_hold;
  logic w_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic awready, next_awready;
  logic wready, next_wready;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic arready, next_arready;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic do_write;

  // Protection state
  logic first_lock_bit, next_first_lock_bit;
  logic second_lock_bit, next_second_lock_bit;
  logic third_lock_bit, next_third_lock_bit;
  logic [1:0] level;
  logic refused, next_refused;
  logic ea_done, next_ea_done;
  logic ea_latch, next_ea_latch;
  logic enc_we;
  logic [5:0] enc_idx;
  logic [7:0] enc_wdata;
  logic [7:0] enc_mem [eprom_lock_pkg::ENC_DEPTH];

  // Core-facing outputs
  eprom_lock_pkg::rsp_s vfy, next_vfy;
  eprom_lock_pkg::rsp_s tbl, next_tbl;
  logic ea_out, next_ea_out;
  logic ext_exec, next_ext_exec;
  logic prog_ok, next_prog_ok;
  logic [1:0] lvl_out, next_lvl_out;

  // Highest programmed bit wins, so mixed patterns lock hardest
  always_comb begin
    if (third_lock_bit) begin // [R12] [R9]
      level = eprom_lock_pkg::LVL_NO_EXT;
    end else if (second_lock_bit) begin // [R8]
      level = eprom_lock_pkg::LVL_NO_VFY;
    end else if (first_lock_bit) begin // [R7]
      level = eprom_lock_pkg::LVL_NO_PROG;
    end else begin // [R6]
      level = eprom_lock_pkg::LVL_OPEN;
    end
  end

  assign do_write = aw_hold && w_hold && !bvalid;

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    // Comes up on the first edge after reset and whenever no read is open
    next_arready = arready || !rvalid;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (S_AXI_AWVALID_I && awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && wready) begin
      next_w_hold = 1'b1;
      next_w_data = S_AXI_WDATA_I;
      next_w_strb = S_AXI_WSTRB_I;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      unique case (aw_addr)
        eprom_lock_pkg::LOCK_CTRL_OFS,
        eprom_lock_pkg::ENC_PROG_OFS,
        eprom_lock_pkg::PROT_STAT_OFS:
          next_bresp = eprom_lock_pkg::RESP_OKAY;
        default:
          next_bresp = eprom_lock_pkg::RESP_SLVERR; // [R11]
      endcase
    end else if (bvalid && S_AXI_BREADY_I) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready = !next_w_hold && !next_bvalid;
    if (S_AXI_ARVALID_I && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = eprom_lock_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      unique case (S_AXI_ARADDR_I)
        eprom_lock_pkg::LOCK_CTRL_OFS: begin
          next_rdata[2:0] = {third_lock_bit, second_lock_bit,
                             first_lock_bit};
          next_rdata[eprom_lock_pkg::LEVEL_LSB +: 2] = level;
        end
        eprom_lock_pkg::ENC_PROG_OFS: begin
          next_rdata[eprom_lock_pkg::STAT_PROG_OK] = prog_ok;
        end
        eprom_lock_pkg::PROT_STAT_OFS: begin
          next_rdata[eprom_lock_pkg::STAT_REFUSED] = refused;
          next_rdata[eprom_lock_pkg::STAT_EA_VAL] = ea_latch;
          next_rdata[eprom_lock_pkg::STAT_EA_DONE] = ea_done;
          next_rdata[eprom_lock_pkg::STAT_PROG_OK] = prog_ok;
        end
        eprom_lock_pkg::SIGNATURE_OFS: begin
          next_rdata = SIGNATURE; // [R11]
        end
        default: begin
          next_rresp = eprom_lock_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid && S_AXI_RREADY_I) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= eprom_lock_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= eprom_lock_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Writes only ever take lock bits from unprogrammed to programmed; reset clears them
  always_comb begin
    next_first_lock_bit = first_lock_bit;
    next_second_lock_bit = second_lock_bit;
    next_third_lock_bit = third_lock_bit;
    next_refused = refused;
    next_ea_done = 1'b1;
    next_ea_latch = ea_latch;
    enc_we = 1'b0;
    enc_idx = w_data[eprom_lock_pkg::ENC_IDX_LSB +:
                     eprom_lock_pkg::ENC_IDX_W];
    enc_wdata = w_data[7:0];
    // Pin level caught on the first edge after reset release
    if (!ea_done) begin
      next_ea_latch = EXTERNAL_ACCESS_SELECT_I; // [R7]
    end
    if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        eprom_lock_pkg::LOCK_CTRL_OFS: begin
          next_first_lock_bit = first_lock_bit | w_data[0]; // [R5]
          next_second_lock_bit = second_lock_bit | w_data[1]; // [R5]
          next_third_lock_bit = third_lock_bit | w_data[2]; // [R5]
        end
        eprom_lock_pkg::ENC_PROG_OFS: begin
          if (level == eprom_lock_pkg::LVL_OPEN && w_strb[1]) begin
            enc_we = 1'b1;
          end else begin
            next_refused = 1'b1; // [R7]
          end
        end
        eprom_lock_pkg::PROT_STAT_OFS: begin
          if (w_data[eprom_lock_pkg::STAT_REFUSED]) begin
            next_refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      first_lock_bit <= 1'b0;
      second_lock_bit <= 1'b0;
      third_lock_bit <= 1'b0;
      refused <= 1'b0;
      ea_done <= 1'b0;
      ea_latch <= 1'b0;
    end else begin
      first_lock_bit <= next_first_lock_bit;
      second_lock_bit <= next_second_lock_bit;
      third_lock_bit <= next_third_lock_bit;
      refused <= next_refused;
      ea_done <= next_ea_done;
      ea_latch <= next_ea_latch;
    end
  end

  // Programming can only clear bits, as an EPROM cell would
  for (genvar i = 0; i < eprom_lock_pkg::ENC_DEPTH; i++) begin : g_enc
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        enc_mem[i] <= eprom_lock_pkg::ERASED_BYTE; // [R1]
      end else if (enc_we && enc_idx == 6'(i)) begin
        enc_mem[i] <= enc_mem[i] & enc_wdata;
      end
    end
  end

  always_comb begin
    next_vfy = eprom_lock_pkg::RSP_IDLE;
    next_tbl = eprom_lock_pkg::RSP_IDLE;
    if (VFY_REQ_I) begin
      next_vfy.valid = 1'b1;
      if (level >= eprom_lock_pkg::LVL_NO_VFY) begin // [R8]
        next_vfy.deny = 1'b1;
        next_vfy.data = eprom_lock_pkg::DENIED_BYTE;
      end else begin
        // Erased code bytes expose the key; fill them with noise [R4]
        next_vfy.data = ~(VFY_CODE_I ^
          enc_mem[VFY_ADDR_I[eprom_lock_pkg::ENC_IDX_W-1:0]]); // [R2] [R3]
      end
    end
    if (TBL_RD_REQ_I) begin
      next_tbl.valid = 1'b1;
      if (TBL_RD_EXT_I && level >= eprom_lock_pkg::LVL_NO_PROG) begin
        next_tbl.deny = 1'b1; // [R7]
        next_tbl.data = eprom_lock_pkg::DENIED_BYTE;
      end else begin
        next_tbl.data = TBL_RD_CODE_I; // [R6]
      end
    end
    if (level >= eprom_lock_pkg::LVL_NO_PROG && ea_done) begin
      next_ea_out = ea_latch; // [R7]
    end else begin
      next_ea_out = EXTERNAL_ACCESS_SELECT_I;
    end
    next_ext_exec = (level != eprom_lock_pkg::LVL_NO_EXT); // [R9]
    // Lock before sign-off leaves no way back [R10]
    next_prog_ok = (level == eprom_lock_pkg::LVL_OPEN); // [R7]
    next_lvl_out = level;
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      vfy <= eprom_lock_pkg::RSP_IDLE;
      tbl <= eprom_lock_pkg::RSP_IDLE;
      ea_out <= 1'b0;
      ext_exec <= 1'b1;
      prog_ok <= 1'b1;
      lvl_out <= eprom_lock_pkg::LVL_OPEN;
    end else begin
      vfy <= next_vfy;
      tbl <= next_tbl;
      ea_out <= next_ea_out;
      ext_exec <= next_ext_exec;
      prog_ok <= next_prog_ok;
      lvl_out <= next_lvl_out;
    end
  end

  assign S_AXI_AWREADY_O = awready;
  assign S_AXI_WREADY_O = wready;
  assign S_AXI_BVALID_O = bvalid;
  assign S_AXI_BRESP_O = bresp;
  assign S_AXI_ARREADY_O = arready;
  assign S_AXI_RVALID_O = rvalid;
  assign S_AXI_RRESP_O = rresp;
  assign S_AXI_RDATA_O = rdata;
  assign VFY_VALID_O = vfy.valid;
  assign VFY_DENY_O = vfy.deny;
  assign VFY_DATA_O = vfy.data;
  assign TBL_RD_VALID_O = tbl.valid;
  assign TBL_RD_DENY_O = tbl.deny;
  assign TBL_RD_DATA_O = tbl.data;
  assign EXTERNAL_ACCESS_SELECT_O = ea_out;
  assign EXT_EXEC_ALLOW_O = ext_exec;
  assign CODE_PROG_ALLOW_O = prog_ok;
  assign PROT_LEVEL_O = lvl_out;

endmodule // eprom_lock_protection
`default_nettype wire

// ==== eprom_lock_pkg.sv ====
// Constants and carriers for the program-memory protection block
package eprom_lock_pkg;
  localparam int ENC_DEPTH = 64;
  localparam int ENC_IDX_W = 6;
  localparam int CODE_ADDR_W = 16;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] DENIED_BYTE = 8'hFF;
  localparam logic [AXI_ADDR_W-1:0] LOCK_CTRL_OFS = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] ENC_PROG_OFS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] PROT_STAT_OFS = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] SIGNATURE_OFS = 8'h0C;
  localparam int LEVEL_LSB = 4;
  localparam int ENC_IDX_LSB = 8;
  localparam int STAT_REFUSED = 0;
  localparam int STAT_EA_VAL = 1;
  localparam int STAT_EA_DONE = 2;
  localparam int STAT_PROG_OK = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Level codes: 0 is level 1 (open) up to 3 is level 4
  localparam logic [1:0] LVL_OPEN = 2'h0;
  localparam logic [1:0] LVL_NO_PROG = 2'h1;
  localparam logic [1:0] LVL_NO_VFY = 2'h2;
  localparam logic [1:0] LVL_NO_EXT = 2'h3;
  typedef struct packed {
    logic valid;
    logic deny;
    logic [7:0] data;
  } rsp_s;
  localparam rsp_s RSP_IDLE = '{valid: 1'b0, deny: 1'b0, data: 8'h00};
endpackage

// ==== code_source.sv ====
// Programmer-side code store answering verify fetches
`timescale 1ns/10ps
`default_nettype none
module code_source (
  input wire logic [15:0] addr_i,
  output logic [7:0] code_o
);
  // Bytes vary over the space, so few look erased
  assign code_o = addr_i[15:8];
endmodule // code_source
`default_nettype wire

// ==== eprom_lock_asserts.sv ====
// Port checker for the protection block
`timescale 1ns/10ps
`default_nettype none
module eprom_lock_asserts (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic VFY_REQ_I,
  input wire logic VFY_VALID_O,
  input wire logic VFY_DENY_O,
  input wire logic [7:0] VFY_DATA_O,
  input wire logic TBL_RD_REQ_I,
  input wire logic TBL_RD_EXT_I,
  input wire logic [7:0] TBL_RD_CODE_I,
  input wire logic TBL_RD_VALID_O,
  input wire logic TBL_RD_DENY_O,
  input wire logic [7:0] TBL_RD_DATA_O,
  input wire logic EXTERNAL_ACCESS_SELECT_O,
  input wire logic EXT_EXEC_ALLOW_O,
  input wire logic CODE_PROG_ALLOW_O,
  input wire logic [1:0] PROT_LEVEL_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Level output lags one cycle, so open means open on both cycles
  sequence s_vfy_open;
    VFY_REQ_I && PROT_LEVEL_O < 2'h2 ##1 PROT_LEVEL_O < 2'h2;
  endsequence
  property p_vfy_pulse; VFY_VALID_O == $past(VFY_REQ_I); endproperty
  a_vfy_pulse: assert property (p_vfy_pulse)
    else $error("verify answer timing");
  property p_vfy_open; s_vfy_open |-> VFY_VALID_O && !VFY_DENY_O; endproperty
  a_vfy_open: assert property (p_vfy_open)
    else $error("open verify denied");
  property p_vfy_deny;
    VFY_REQ_I && PROT_LEVEL_O >= 2'h2 |=> VFY_DENY_O && VFY_DATA_O == 8'hFF;
  endproperty
  a_vfy_deny: assert property (p_vfy_deny)
    else $error("locked verify answered");
  property p_tbl_int;
    TBL_RD_REQ_I && !TBL_RD_EXT_I |=> TBL_RD_VALID_O && !TBL_RD_DENY_O
      && TBL_RD_DATA_O == $past(TBL_RD_CODE_I);
  endproperty
  a_tbl_int: assert property (p_tbl_int)
    else $error("internal table read altered");
  property p_tbl_deny;
    TBL_RD_REQ_I && TBL_RD_EXT_I && PROT_LEVEL_O != 2'h0 |=>
      TBL_RD_DENY_O && TBL_RD_DATA_O == 8'hFF;
  endproperty
  a_tbl_deny: assert property (p_tbl_deny)
    else $error("external table read leaked");
  property p_prog; CODE_PROG_ALLOW_O == (PROT_LEVEL_O == 2'h0); endproperty
  a_prog: assert property (p_prog)
    else $error("programming gate wrong");
  property p_exec; EXT_EXEC_ALLOW_O == (PROT_LEVEL_O != 2'h3); endproperty
  a_exec: assert property (p_exec)
    else $error("external execution gate wrong");
  property p_mono; PROT_LEVEL_O >= $past(PROT_LEVEL_O); endproperty
  a_mono: assert property (p_mono)
    else $error("level fell");
  property p_ea_hold;
    PROT_LEVEL_O != 2'h0 && $past(PROT_LEVEL_O) != 2'h0 |->
      $stable(EXTERNAL_ACCESS_SELECT_O);
  endproperty
  a_ea_hold: assert property (p_ea_hold)
    else $error("latched access pin moved");
endmodule // eprom_lock_asserts
bind eprom_lock_protection eprom_lock_asserts CHK (.MCLK_I, .SYS_RST_I,
  .VFY_REQ_I, .VFY_VALID_O, .VFY_DENY_O, .VFY_DATA_O, .TBL_RD_REQ_I,
  .TBL_RD_EXT_I, .TBL_RD_CODE_I, .TBL_RD_VALID_O, .TBL_RD_DENY_O,
  .TBL_RD_DATA_O, .EXTERNAL_ACCESS_SELECT_O, .EXT_EXEC_ALLOW_O,
  .CODE_PROG_ALLOW_O, .PROT_LEVEL_O);
`default_nettype wire

// ==== eprom_lock_protection_bench.sv ====
// Register and access bench for the protection block
`timescale 1ns/10ps
`default_nettype none
module eprom_lock_protection_bench;
  localparam logic [31:0] SIG = 32'h1357_9BDF; // Arbitrary value
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0;
  logic arv = 1'b0, rre = 1'b0, vreq = 1'b0, treq = 1'b0, tx = 1'b0;
  logic ea = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00, tc = 8'h00, vc, vd, td;
  logic [31:0] wd = 32'h0, rdv;
  logic [15:0] va = 16'h0;
  logic [3:0] ws = 4'hF;
  logic [1:0] br, rr, lvl, resp;
  logic awr, wr, bv, arr, rv, vv, vdn, tv, tdn, eao, ex, pa;
  int miscompares = 0, n_compared = 0;
  always #2 clk = ~clk;
  eprom_lock_protection #(.SIGNATURE(SIG)) DUT (
    .MCLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdv), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rre), .VFY_REQ_I(vreq), .VFY_ADDR_I(va),
    .VFY_CODE_I(vc), .VFY_VALID_O(vv), .VFY_DENY_O(vdn),
    .VFY_DATA_O(vd), .TBL_RD_REQ_I(treq), .TBL_RD_EXT_I(tx),
    .TBL_RD_CODE_I(tc), .TBL_RD_VALID_O(tv), .TBL_RD_DENY_O(tdn),
    .TBL_RD_DATA_O(td), .EXTERNAL_ACCESS_SELECT_I(ea),
    .EXTERNAL_ACCESS_SELECT_O(eao), .EXT_EXEC_ALLOW_O(ex),
    .CODE_PROG_ALLOW_O(pa), .PROT_LEVEL_O(lvl));
  code_source SRC (.addr_i(va), .code_o(vc));
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wr === 1'b1) wv <= 1'b0;
      resp = br;
    end while (bv !== 1'b1);
    bre <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr === 1'b1) arv <= 1'b0;
      resp = rr;
    end while (rv !== 1'b1);
    rre <= 1'b0;
    chk(rdv, e);
  endtask
  // Mode 0 verify, 2 internal table read, 3 table read from outside
  task automatic acc(input logic [1:0] m, input logic [15:0] a,
                     input logic [9:0] e);
    @(posedge clk);
    vreq <= !m[1];
    treq <= m[1];
    tx <= m[0];
    va <= a;
    tc <= a[15:8];
    @(posedge clk);
    vreq <= 1'b0;
    treq <= 1'b0;
    @(negedge clk);
    chk({22'h0, m[1] ? {tv, tdn, td} : {vv, vdn, vd}}, {22'h0, e});
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    ea <= 1'b0;
    axr(8'h0C, SIG);
    axw(8'h0C, 32'h0);
    chk({30'h0, resp}, 32'h2);
    axr(8'h0C, SIG);
    axr(8'h10, 32'h0);
    chk({30'h0, resp}, 32'h2);
    axr(8'h00, 32'h0);
    axr(8'h08, 32'hE);
    chk({27'h0, lvl, pa, ex, eao}, 32'h6);
    for (int i = 0; i < 64; i++) begin
      acc(2'h0, {8'hA5 ^ 8'(i), 2'b00, 6'(i)}, {2'b10, 8'hA5 ^ 8'(i)});
    end
    axw(8'h04, 32'h0000_053C);
    acc(2'h0, 16'hFF05, 10'h23C);
    acc(2'h0, 16'h0FC5, {2'b10, ~(8'h0F ^ 8'h3C)});
    acc(2'h0, 16'hFF06, 10'h2FF);
    acc(2'h3, 16'h9600, 10'h296);
    // Locks go on only once verify has been exercised
    axw(8'h00, 32'h1);
    // Level outputs settle one edge after the write response
    @(negedge clk);
    chk({27'h0, lvl, pa, ex, eao}, 32'h0B);
    acc(2'h3, 16'h9600, 10'h3FF);
    acc(2'h2, 16'h9600, 10'h296);
    acc(2'h0, 16'hFF05, 10'h23C);
    axw(8'h04, 32'h0000_0500);
    axr(8'h08, 32'h7);
    acc(2'h0, 16'hFF05, 10'h23C);
    axw(8'h08, 32'h1);
    axr(8'h08, 32'h6);
    axw(8'h00, 32'h2);
    axr(8'h00, 32'h23);
    acc(2'h0, 16'hFF05, 10'h3FF);
    axw(8'h00, 32'h4);
    axr(8'h00, 32'h37);
    chk({27'h0, lvl, pa, ex, eao}, 32'h19);
    give_verdict();
  end
  initial begin
    #20000;
    miscompares++;
    give_verdict();
  end
endmodule // eprom_lock_protection_bench
`default_nettype wire
